// *** dv/revision_enhance_ctrl_assertions.sv ***
// Checker of the enhancement register block, bound to its top module.
`timescale 1ns/1ns
`include "enh_ctrl_consts.svh"
module revision_enhance_ctrl_assertions
(
	// Clock and reset.
	input wire logic ref_clk_i,
	input wire logic srst_i,
	// APB.
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [`ENH_ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	// Enables and arbitration.
	input wire logic [7:0] enh_first_o,
	input wire logic [7:0] enh_second_o,
	input wire logic [7:0] enh_third_o,
	input wire logic dram_suspend_fix_o,
	input wire logic uart_stop_resync_en_o,
	input wire logic uart_loopback_fix_en_o,
	input wire logic arb_reset_o,
	input wire logic dma_hold_ack_o
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (srst_i);
	////////////////////////////////////////////////////////////////
	sequence setup_s;
		psel_i && !penable_i;
	endsequence
	sequence wr_first_s;
		psel_i && penable_i && pready_o && pwrite_i && paddr_i == `ENH_FIRST_ADDR;
	endsequence
	property wr_first_p;
		logic [7:0] d;
		(wr_first_s, d = pwdata_i[7:0]) |=> enh_first_o == d;
	endproperty
	a_setup_gets_ready: assert property (setup_s |=> pready_o)
		else $error("no ready after setup");
	a_ready_one_cycle: assert property (pready_o |=> !pready_o)
		else $error("ready held too long");
	a_first_write_stored: assert property (wr_first_p)
		else $error("first register not written");
	a_dram_fix_bit: assert property (dram_suspend_fix_o == enh_first_o[0])
		else $error("suspend fix differs from its bit");
	a_arb_reset_bit: assert property (arb_reset_o == enh_third_o[4])
		else $error("arbiter reset differs from its bit");
	a_arb_holds_ack: assert property (arb_reset_o |=> !dma_hold_ack_o)
		else $error("hold granted in arbiter reset");
	a_uart_fixes_on: assert property (uart_stop_resync_en_o && uart_loopback_fix_en_o)
		else $error("receive fix switched off");
	a_legacy_after_reset: assert property ($fell(srst_i) |->
		enh_first_o == 8'h00 && enh_second_o == 8'h00 && enh_third_o == 8'h00)
		else $error("enhancement bits set after reset");
	a_unmapped_errors: assert property (setup_s ##0 !(paddr_i inside {`ENH_FIRST_ADDR,
		`ENH_SECOND_ADDR, `ENH_THIRD_ADDR, `ENH_STATUS_ADDR}) |=> pslverr_o && prdata_o == 32'h0)
		else $error("unmapped access not refused");
	a_third_readback: assert property (setup_s ##0 !pwrite_i && paddr_i == `ENH_THIRD_ADDR
		|=> prdata_o == {24'h000000, enh_third_o})
		else $error("third register read wrong");
endmodule
bind revision_enhance_ctrl revision_enhance_ctrl_assertions revision_enhance_ctrl_assertions_i (.*);

// *** dv/revision_enhance_ctrl_tb.sv ***
// Self-checking testbench of the enhancement register block.
`timescale 1ns/1ns
`include "enh_ctrl_consts.svh"
module revision_enhance_ctrl_tb;
	logic ref_clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [`ENH_ADDR_W-1:0] paddr_i = '0;
	logic [31:0] pwdata_i = '0;
	logic system_power_good_i = 1'b1;
	logic dma_hold_request_i = 1'b0;
	logic refresh_active_i = 1'b0;
	logic [31:0] prdata_o;
	logic pready_o, pslverr_o, dram_suspend_fix_o, uart_stop_resync_en_o;
	logic [7:0] enh_first_o, enh_second_o, enh_third_o;
	logic uart_loopback_fix_en_o, cpu_reset_o, arb_reset_o, dma_hold_ack_o;
	logic [31:0] rd;
	logic err;
	int n;
	int mismatches = 0;
	int cmp_count = 0;

	revision_enhance_ctrl revision_enhance_ctrl_i (.*);

	always #50 ref_clk_i = ~ref_clk_i;
	////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task xfer(input logic w, input logic [`ENH_ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge ref_clk_i);
		penable_i <= 1'b1;
		@(posedge ref_clk_i);
		while (pready_o !== 1'b1)
			@(posedge ref_clk_i);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge ref_clk_i);
	endtask

	task rd_chk(input logic [`ENH_ADDR_W-1:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rd, e);
	endtask

	// Waits a bounded time for the CPU reset (s high) or the hold grant to reach v.
	task wait_for(input logic s, input logic v);
		n = 0;
		while ((s ? cpu_reset_o : dma_hold_ack_o) !== v && n < 40)
		begin
			@(posedge ref_clk_i);
			n++;
		end
	endtask

	task finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (3000) @(posedge ref_clk_i);
		mismatches++;
		finish_test;
	end

	initial
	begin
		repeat (20) @(posedge ref_clk_i);
		srst_i <= 1'b0;
		@(posedge ref_clk_i);
		chk(32'({uart_stop_resync_en_o, uart_loopback_fix_en_o}), 32'h3);
		rd_chk(`ENH_FIRST_ADDR, 32'h0);
		rd_chk(`ENH_SECOND_ADDR, 32'h0);
		rd_chk(`ENH_THIRD_ADDR, 32'h0);
		xfer(1'b1, `ENH_FIRST_ADDR, 32'hFFFFFF01);
		chk({enh_third_o, enh_second_o, enh_first_o, 7'h0, dram_suspend_fix_o}, 32'h101);
		rd_chk(`ENH_FIRST_ADDR, 32'h1);
		xfer(1'b1, `ENH_SECOND_ADDR, 32'hA5);
		rd_chk(`ENH_SECOND_ADDR, 32'hA5);
		chk(32'(enh_first_o), 32'h1);
		xfer(1'b0, 12'h000, 32'h0);
		chk({err, rd[30:0]}, 32'h80000000);
		xfer(1'b1, 12'h390, 32'hFF);
		rd_chk(`ENH_FIRST_ADDR, 32'h1);
		dma_hold_request_i <= 1'b1;
		wait_for(1'b0, 1'b1);
		chk(32'(dma_hold_ack_o), 32'h1);
		system_power_good_i <= 1'b0;
		wait_for(1'b1, 1'b1);
		chk(32'({cpu_reset_o, dma_hold_ack_o}), 32'h3);
		system_power_good_i <= 1'b1;
		wait_for(1'b1, 1'b0);
		chk(32'(cpu_reset_o), 32'h0);
		// Refresh running shows in the status word that software polls.
		refresh_active_i <= 1'b1;
		repeat (5) @(posedge ref_clk_i);
		rd_chk(`ENH_STATUS_ADDR, 32'h2D);
		refresh_active_i <= 1'b0;
		repeat (5) @(posedge ref_clk_i);
		rd_chk(`ENH_STATUS_ADDR, 32'h0D);
		xfer(1'b1, `ENH_THIRD_ADDR, 32'h10);
		chk(32'(arb_reset_o), 32'h1);
		repeat (2) @(posedge ref_clk_i);
		chk(32'(dma_hold_ack_o), 32'h0);
		// Software masks DMA before it releases the arbiter.
		dma_hold_request_i <= 1'b0;
		xfer(1'b1, `ENH_STATUS_ADDR, 32'h1);
		rd_chk(`ENH_STATUS_ADDR, 32'h0A);
		xfer(1'b1, `ENH_THIRD_ADDR, 32'h0);
		chk(32'(arb_reset_o), 32'h0);
		repeat (4) @(posedge ref_clk_i);
		chk(32'(dma_hold_ack_o), 32'h0);
		dma_hold_request_i <= 1'b1;
		wait_for(1'b0, 1'b1);
		chk(32'(dma_hold_ack_o), 32'h1);
		// Power lost again in the middle of the resume count goes back to OFF.
		system_power_good_i <= 1'b0;
		wait_for(1'b1, 1'b1);
		system_power_good_i <= 1'b1;
		repeat (8) @(posedge ref_clk_i);
		system_power_good_i <= 1'b0;
		repeat (12) @(posedge ref_clk_i);
		chk(32'(cpu_reset_o), 32'h1);
		rd_chk(`ENH_STATUS_ADDR, 32'h14);
		// A second hardware reset in mid-run returns the first and second registers to legacy.
		system_power_good_i <= 1'b1;
		srst_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		srst_i <= 1'b0;
		@(posedge ref_clk_i);
		chk(32'({enh_first_o, enh_second_o, cpu_reset_o}), 32'h0);
		rd_chk(`ENH_FIRST_ADDR, 32'h0);
		rd_chk(`ENH_SECOND_ADDR, 32'h0);
		finish_test;
	end
endmodule

// *** verilog/bus_arbiter.sv ***
// Local bus arbiter between the CPU and the DMA controller.
`timescale 1ns/1ns
module bus_arbiter
	import enh_ctrl_pkg::*;
(
	// Clock and reset.
	input wire logic ref_clk_i,
	input wire logic srst_i,
	// Software arbitration reset, held while high.
	input wire logic arb_reset_i,
	// DMA hold request and acknowledge.
	input wire logic dma_hold_request_i,
	output logic hold_ack_o,
	output logic dma_owns_o
);

	arb_s state_r;
	arb_s state_nxt;

	always_comb
	begin
		state_nxt = state_r;
		if (arb_reset_i)
		begin
			// Back to the CPU-owns state, in step with a freshly reset CPU.
			state_nxt.state = ARB_CPU;
			state_nxt.hold_ack = 1'b0;
		end
		else
		begin
			unique case (state_r.state)
				ARB_CPU:
				begin
					if (dma_hold_request_i)
					begin
						state_nxt.state = ARB_DMA;
						state_nxt.hold_ack = 1'b1;
					end
				end
				ARB_DMA:
				begin
					if (!dma_hold_request_i)
					begin
						state_nxt.state = ARB_CPU;
						state_nxt.hold_ack = 1'b0;
					end
				end
				default:
				begin
					state_nxt.state = ARB_CPU;
					state_nxt.hold_ack = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			state_r <= '{ARB_CPU, 1'b0};
		end
		else
		begin
			state_r <= state_nxt;
		end
	end

	assign hold_ack_o = state_r.hold_ack;
	assign dma_owns_o = (state_r.state == ARB_DMA);

endmodule

// *** verilog/enh_ctrl_consts.svh ***
// Constants of the revision enhancement control block.
// What this block does
// - Three enhancement registers, one index each
// - Legacy behaviour after reset until bits set
// - Every enhancement but the UART fixes has its own enable bit
// - UART resyncs after short stop at 2400
// - UART loopback test passes at 9600 baud
// - UART receive fixes always on, no bit
// - First register D0 enables DRAM suspend fix
// - OFF mode resets CPU, never the arbiter
// - Third register D4 holds arbiter in reset
// - Arbiter release resynchronises with the CPU
`ifndef ENH_CTRL_CONSTS_SVH
`define ENH_CTRL_CONSTS_SVH

`define ENH_ADDR_W 12
`define ENH_FIRST_IDX 8'hE0
`define ENH_SECOND_IDX 8'hE1
`define ENH_THIRD_IDX 8'hE2
`define ENH_STATUS_IDX 8'hE3
`define ENH_FIRST_ADDR {2'h0, `ENH_FIRST_IDX, 2'h0}
`define ENH_SECOND_ADDR {2'h0, `ENH_SECOND_IDX, 2'h0}
`define ENH_THIRD_ADDR {2'h0, `ENH_THIRD_IDX, 2'h0}
`define ENH_STATUS_ADDR {2'h0, `ENH_STATUS_IDX, 2'h0}

`define ENH_RESET_VAL 8'h00
`define ENH1_DRAM_SUSPEND_BIT 0
`define ENH3_ARB_RESET_BIT 4

`define STAT_RESUMED_BIT 0
`define STAT_ARB_RESET_BIT 1
`define STAT_DMA_OWNS_BIT 2
`define STAT_PWR_GOOD_BIT 3
`define STAT_CPU_RESET_BIT 4
`define STAT_REFRESH_BIT 5

`define CLK_PERIOD_NS 100
`define CPU_RST_HOLD_NS 1000
`define CPU_RST_CYCLES ((`CPU_RST_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** verilog/enh_ctrl_pkg.sv ***
// Types shared by the revision enhancement control block.
package enh_ctrl_pkg;

	typedef enum logic [2:0]
	{
		PWR_ON = 3'h1,
		PWR_OFF = 3'h2,
		PWR_RESUME = 3'h4
	} power_state_e;

	typedef enum logic [1:0]
	{
		ARB_CPU = 2'h1,
		ARB_DMA = 2'h2
	} arb_state_e;

	typedef logic [7:0] rst_cnt_t;

	typedef struct packed
	{
		logic stage1;
		logic stage2;
		logic stage3;
		logic level;
	} sync_s;

	typedef struct packed
	{
		arb_state_e state;
		logic hold_ack;
	} arb_s;

endpackage

// *** verilog/pin_sync.sv ***
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ns
module pin_sync
	import enh_ctrl_pkg::*;
#(
	parameter logic RESET_LEVEL = 1'b0
)
(
	// Clock and reset.
	input wire logic ref_clk_i,
	input wire logic srst_i,
	// Pin and filtered level.
	input wire logic pin_i,
	output logic level_o
);

	sync_s state_r;
	sync_s state_nxt;

	always_comb
	begin
		state_nxt = state_r;
		state_nxt.stage1 = pin_i;
		state_nxt.stage2 = state_r.stage1;
		state_nxt.stage3 = state_r.stage2;
		if (state_r.stage2 == state_r.stage3)
		begin
			state_nxt.level = state_r.stage3;
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			state_r <= '{RESET_LEVEL, RESET_LEVEL, RESET_LEVEL, RESET_LEVEL};
		end
		else
		begin
			state_r <= state_nxt;
		end
	end

	assign level_o = state_r.level;

endmodule

// *** verilog/revision_enhance_ctrl.sv ***
// Enhancement registers on APB, OFF mode CPU reset and software arbiter reset.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
`include "enh_ctrl_consts.svh"
module revision_enhance_ctrl
	import enh_ctrl_pkg::*;
(
	// Clock and reset.
	input wire logic ref_clk_i,
	input wire logic srst_i,
	// APB slave.
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [`ENH_ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// System pins.
	input wire logic system_power_good_i,
	input wire logic dma_hold_request_i,
	input wire logic refresh_active_i,
	// Enhancement enables towards the chip.
	output logic [7:0] enh_first_o,
	output logic [7:0] enh_second_o,
	output logic [7:0] enh_third_o,
	output logic dram_suspend_fix_o,
	output logic uart_stop_resync_en_o,
	output logic uart_loopback_fix_en_o,
	// CPU and arbitration control.
	output logic cpu_reset_o,
	output logic arb_reset_o,
	output logic dma_hold_ack_o
);

	////////////////////////////////////////////////////////////////////////////////

	typedef struct packed
	{
		logic [7:0] enh_first;
		logic [7:0] enh_second;
		logic [7:0] enh_third;
		logic resumed_off;
		power_state_e pwr;
		rst_cnt_t rst_cnt;
		logic cpu_reset;
		logic dram_fix;
		logic arb_reset;
		logic uart_stop_fix;
		logic uart_loop_fix;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} ctrl_s;

	localparam rst_cnt_t RST_CYCLES = rst_cnt_t'(`CPU_RST_CYCLES);

	ctrl_s ctrl_r;
	ctrl_s ctrl_nxt;

	logic pwr_good_s;
	logic hold_req_s;
	logic refresh_s;
	logic hold_ack;
	logic dma_owns;

	////////////////////////////////////////////////////////////////////////////////

	// Pins from outside the clock domain pass four flip-flops (three stages and the level) before use.
	pin_sync #(
		.RESET_LEVEL(1'b1)
	) u_pwr_good_sync (
		.ref_clk_i(ref_clk_i),
		.srst_i(srst_i),
		.pin_i(system_power_good_i),
		.level_o(pwr_good_s)
	);

	pin_sync #(
		.RESET_LEVEL(1'b0)
	) u_hold_req_sync (
		.ref_clk_i(ref_clk_i),
		.srst_i(srst_i),
		.pin_i(dma_hold_request_i),
		.level_o(hold_req_s)
	);

	pin_sync #(
		.RESET_LEVEL(1'b0)
	) u_refresh_sync (
		.ref_clk_i(ref_clk_i),
		.srst_i(srst_i),
		.pin_i(refresh_active_i),
		.level_o(refresh_s)
	);

	// The arbiter sees the hardware reset and the software reset, never the CPU reset.
	bus_arbiter u_arbiter (
		.ref_clk_i(ref_clk_i),
		.srst_i(srst_i),
		.arb_reset_i(ctrl_r.arb_reset),
		.dma_hold_request_i(hold_req_s),
		.hold_ack_o(hold_ack),
		.dma_owns_o(dma_owns)
	);

	////////////////////////////////////////////////////////////////////////////////

	logic setup_phase;
	logic write_done;
	logic sel_first;
	logic sel_second;
	logic sel_third;
	logic sel_status;
	logic addr_hit;
	logic [31:0] status_word;
	logic [31:0] read_word;
	logic resume_done;

	// Address decode, status word and read data for the APB slave.
	always_comb
	begin
		setup_phase = psel_i && !penable_i;
		write_done = psel_i && penable_i && ctrl_r.pready && pwrite_i && !ctrl_r.pslverr;
		sel_first = (paddr_i == `ENH_FIRST_ADDR);
		sel_second = (paddr_i == `ENH_SECOND_ADDR);
		sel_third = (paddr_i == `ENH_THIRD_ADDR);
		sel_status = (paddr_i == `ENH_STATUS_ADDR);
		addr_hit = sel_first || sel_second || sel_third || sel_status;

		status_word = 32'h0000_0000;
		status_word[`STAT_RESUMED_BIT] = ctrl_r.resumed_off;
		status_word[`STAT_ARB_RESET_BIT] = ctrl_r.arb_reset;
		status_word[`STAT_DMA_OWNS_BIT] = dma_owns;
		status_word[`STAT_PWR_GOOD_BIT] = pwr_good_s;
		status_word[`STAT_CPU_RESET_BIT] = ctrl_r.cpu_reset;
		// Software polls this before asserting the arbiter reset.
		status_word[`STAT_REFRESH_BIT] = refresh_s;

		read_word = 32'h0000_0000;
		if (sel_first)
		begin
			read_word = {24'h00_0000, ctrl_r.enh_first};
		end
		else if (sel_second)
		begin
			read_word = {24'h00_0000, ctrl_r.enh_second};
		end
		else if (sel_third)
		begin
			read_word = {24'h00_0000, ctrl_r.enh_third};
		end
		else if (sel_status)
		begin
			read_word = status_word;
		end

		// The resume count ends in the cycle in which the counter stands at one.
		resume_done = (ctrl_r.pwr == PWR_RESUME) && (ctrl_r.rst_cnt == rst_cnt_t'(1));
	end

	////////////////////////////////////////////////////////////////////////////////

	always_comb
	begin
		ctrl_nxt = ctrl_r;

		// Zero-wait answer: pready rises in the first access cycle.
		ctrl_nxt.pready = setup_phase;
		if (setup_phase)
		begin
			ctrl_nxt.pslverr = !addr_hit;
			ctrl_nxt.prdata = pwrite_i ? 32'h0000_0000 : read_word;
		end
		else if (!(psel_i && penable_i))
		begin
			ctrl_nxt.pslverr = 1'b0;
			ctrl_nxt.prdata = 32'h0000_0000;
		end

		// Each register byte is written whole; every bit is a separate enable.
		if (write_done && sel_first)
		begin
			ctrl_nxt.enh_first = pwdata_i[7:0];
		end
		if (write_done && sel_second)
		begin
			ctrl_nxt.enh_second = pwdata_i[7:0];
		end
		if (write_done && sel_third)
		begin
			ctrl_nxt.enh_third = pwdata_i[7:0];
		end

		// Enables follow the register bits, except the UART fixes, which stay on; a cleared bit means legacy behaviour.
		ctrl_nxt.dram_fix = ctrl_nxt.enh_first[`ENH1_DRAM_SUSPEND_BIT];
		ctrl_nxt.arb_reset = ctrl_nxt.enh_third[`ENH3_ARB_RESET_BIT];
		ctrl_nxt.uart_stop_fix = 1'b1;
		ctrl_nxt.uart_loop_fix = 1'b1;

		// Power loss takes the CPU into reset and holds it through the resume.
		unique case (ctrl_r.pwr)
			PWR_ON:
			begin
				if (!pwr_good_s)
				begin
					ctrl_nxt.pwr = PWR_OFF;
					ctrl_nxt.cpu_reset = 1'b1;
				end
			end
			PWR_OFF:
			begin
				ctrl_nxt.cpu_reset = 1'b1;
				if (pwr_good_s)
				begin
					ctrl_nxt.pwr = PWR_RESUME;
					ctrl_nxt.rst_cnt = RST_CYCLES;
				end
			end
			PWR_RESUME:
			begin
				if (!pwr_good_s)
				begin
					ctrl_nxt.pwr = PWR_OFF;
				end
				else if (resume_done)
				begin
					ctrl_nxt.pwr = PWR_ON;
					ctrl_nxt.cpu_reset = 1'b0;
					ctrl_nxt.rst_cnt = rst_cnt_t'(0);
				end
				else
				begin
					ctrl_nxt.rst_cnt = ctrl_r.rst_cnt - rst_cnt_t'(1);
				end
			end
			default:
			begin
				ctrl_nxt.pwr = PWR_ON;
				ctrl_nxt.cpu_reset = 1'b0;
			end
		endcase

		// Resume flag: write one to clear, a new resume in the same cycle wins.
		if (write_done && sel_status && pwdata_i[`STAT_RESUMED_BIT])
		begin
			ctrl_nxt.resumed_off = 1'b0;
		end
		if (resume_done && pwr_good_s)
		begin
			ctrl_nxt.resumed_off = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	// Synchronous reset returns every enable to legacy; the UART fixes stay on.
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			ctrl_r.enh_first <= `ENH_RESET_VAL;
			ctrl_r.enh_second <= `ENH_RESET_VAL;
			ctrl_r.enh_third <= `ENH_RESET_VAL;
			ctrl_r.resumed_off <= 1'b0;
			ctrl_r.pwr <= PWR_ON;
			ctrl_r.rst_cnt <= rst_cnt_t'(0);
			ctrl_r.cpu_reset <= 1'b0;
			ctrl_r.dram_fix <= 1'b0;
			ctrl_r.arb_reset <= 1'b0;
			ctrl_r.uart_stop_fix <= 1'b1;
			ctrl_r.uart_loop_fix <= 1'b1;
			ctrl_r.pready <= 1'b0;
			ctrl_r.pslverr <= 1'b0;
			ctrl_r.prdata <= 32'h0000_0000;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	// Software masks DMA before releasing the arbiter; the hold acknowledge stays low meanwhile.
	always_comb
	begin
		prdata_o = ctrl_r.prdata;
		pready_o = ctrl_r.pready;
		pslverr_o = ctrl_r.pslverr;
		enh_first_o = ctrl_r.enh_first;
		enh_second_o = ctrl_r.enh_second;
		enh_third_o = ctrl_r.enh_third;
		dram_suspend_fix_o = ctrl_r.dram_fix;
		uart_stop_resync_en_o = ctrl_r.uart_stop_fix;
		uart_loopback_fix_en_o = ctrl_r.uart_loop_fix;
		cpu_reset_o = ctrl_r.cpu_reset;
		arb_reset_o = ctrl_r.arb_reset;
		dma_hold_ack_o = hold_ack;
	end

endmodule
